// [delay_timer.sv]
`timescale 1ns/1ps
`default_nettype none
// counts cycles while a condition holds, flags when the target is reached
module delay_timer #(
  parameter int LIMIT = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  output logic done
);
  logic [mode_pkg::CNT_W-1:0] count;

  // ----------------------------------------
  // counter
  // ----------------------------------------
  // restarts whenever the condition drops, so only a steady condition counts
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      count <= '0;
      done <= 1'b0;
    end
    else if (!run)
    begin
      count <= '0;
      done <= 1'b0;
    end
    else if (count >= mode_pkg::CNT_W'(LIMIT))
      done <= 1'b1;
    else
      count <= count + 1'b1;
  end
endmodule
`default_nettype wire

// [mcu_model.sv]
`timescale 1ns/1ps
`default_nettype none
// controller side: drives both bridge inputs as levels and watches the flag
module mcu_model (
  // clock
  input wire logic clk,
  // bench commands
  input wire logic want_a,
  input wire logic want_b,
  // device pins
  input wire logic fault_flag_n,
  output logic bridge_ctrl_a,
  output logic bridge_ctrl_b,
  output logic fault_seen
);
  // ----------------------------------------
  // pin drive
  // ----------------------------------------
  // known levels from time zero, the pins have pulldowns on the real part
  initial
  begin
    bridge_ctrl_a = 1'b0;
    bridge_ctrl_b = 1'b0;
    fault_seen = 1'b1;
  end
  // launched just after the edge, held until the bench asks for a change
  always @(posedge clk)
  begin
    bridge_ctrl_a <= want_a;
    bridge_ctrl_b <= want_b;
    fault_seen <= fault_flag_n;
  end
endmodule
`default_nettype wire

// [mode_pkg.sv]
// What this block does
// [R1] the bridge and internal circuits run whenever either bridge control input is high and no fault stands.
// [R2] active mode is entered only once supply is good, the inputs are not both low, and the wake delay has passed.
// the code also enters it from fault mode on recovery, without checking the inputs or the wake delay.
// [R3] in active mode the bridge, charge pump and logic run and input changes are followed.
// [R4] both inputs low for the sleep delay puts the device to sleep; the controller must hold them that long.
// [R5] asleep, both bridge outputs are high impedance and internal circuits are off.
// [R6] an input high for longer than the wake delay wakes the device; the controller must hold it that long.
// [R7] any fault enters fault mode, disables the bridge and pulls the fault flag low.
// [R8] fault mode is left for active mode once the recovery condition of the causing fault holds.
// [R9] single supply: motor supply undervoltage disables bridge and circuits and flags a fault until it rises.
// [R10] split supply: logic supply undervoltage disables bridge and circuits and flags a fault until it rises.
// [R11] split supply: normal operation at any motor supply, current sense only while motor supply is above 1.65 V.
// [R12] single supply: current sense and operation at or above 1.65 V motor supply, lockout below.
// [R13] after thermal shutdown the bridge stays off until temperature is below trip minus hysteresis.
// [R14] after overcurrent or thermal shutdown the bridge re-enables after the retry period, repeating while it lasts.
// [R15] undervoltage resets all internal logic, disables the outputs and pulls the fault flag low; here the sleep timer and synchronisers keep running.
package mode_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int WAKE_US = 1;
  localparam int SLEEP_US = 1;
  localparam int RETRY_US = 1;
  localparam int WAKE_CYCLES = WAKE_US * CLK_MHZ;
  localparam int SLEEP_CYCLES = SLEEP_US * CLK_MHZ;
  localparam int RETRY_CYCLES = RETRY_US * CLK_MHZ;
  localparam int CNT_W = 16;

  // ----------------------------------------
  // modes and carriers
  // ----------------------------------------
  typedef enum logic [3:0] {
    ST_LOCKOUT = 4'h1,
    ST_SLEEP = 4'h2,
    ST_ACTIVE = 4'h4,
    ST_FAULT = 4'h8
  } mode_type;

  typedef struct packed {
    logic bridge_en;
    logic circuits_en;
    logic sense_en;
    logic fault_flag_n_oe;
  } drive_type;

  localparam drive_type DRIVE_RESET = 4'h1;

endpackage

// [motor_driver_mode_fault_control.sv]
`timescale 1ns/1ps
`default_nettype none
module motor_driver_mode_fault_control (
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_RST,
  // controller inputs
  input wire logic I_BRIDGE_CTRL_A,
  input wire logic I_BRIDGE_CTRL_B,
  // variant strap: high for split supply
  input wire logic I_SPLIT_SUPPLY,
  // analog comparator results
  input wire logic I_LOGIC_SUPPLY_OK,
  input wire logic I_MOTOR_SUPPLY_OK,
  input wire logic I_OVERCURRENT,
  input wire logic I_OVER_THERMAL_TRIP,
  input wire logic I_BELOW_THERMAL_HYSTERESIS,
  // outputs
  output logic O_BRIDGE_EN,
  output logic O_BRIDGE_HIZ,
  output logic O_CIRCUITS_EN,
  output logic O_CURRENT_SENSE_OUT_EN,
  output logic O_FAULT_FLAG_N_OUT,
  output logic O_FAULT_FLAG_N_OE
);

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [7:0] sync1;
  logic [7:0] sync2;
  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      sync1 <= 8'h00;
      sync2 <= 8'h00;
    end
    else
    begin
      sync1 <= {I_BRIDGE_CTRL_A, I_BRIDGE_CTRL_B, I_SPLIT_SUPPLY, I_LOGIC_SUPPLY_OK,
                I_MOTOR_SUPPLY_OK, I_OVERCURRENT, I_OVER_THERMAL_TRIP, I_BELOW_THERMAL_HYSTERESIS};
      sync2 <= sync1;
    end
  end

  logic ctrl_a, ctrl_b, split, vcc_ok, vm_ok, ocp, tsd, cool;
  assign {ctrl_a, ctrl_b, split, vcc_ok, vm_ok, ocp, tsd, cool} = sync2;

  // ----------------------------------------
  // supply qualification
  // ----------------------------------------
  logic supply_ok;
  logic any_in;
  // split supply watches the logic rail, single supply the motor rail
  assign supply_ok = split ? vcc_ok : vm_ok; // R9 R10
  assign any_in = ctrl_a | ctrl_b;

  // ----------------------------------------
  // delay timers
  // ----------------------------------------
  mode_pkg::mode_type mode;
  logic wake_done, sleep_done, retry_done, in_fault;
  assign in_fault = (mode == mode_pkg::ST_FAULT);

  // wake delay only counts on a good supply, so it restarts after every lockout
  delay_timer #(.LIMIT(mode_pkg::WAKE_CYCLES)) u_wake (
    .clk(I_CLK), .rst(I_RST), .run(any_in && supply_ok), .done(wake_done) // R2 R15
  );
  delay_timer #(.LIMIT(mode_pkg::SLEEP_CYCLES)) u_sleep (
    .clk(I_CLK), .rst(I_RST), .run(!any_in), .done(sleep_done)
  );
  delay_timer #(.LIMIT(mode_pkg::RETRY_CYCLES)) u_retry (
    .clk(I_CLK), .rst(I_RST), .run(in_fault && supply_ok), .done(retry_done)
  );

  // ----------------------------------------
  // fault cause
  // ----------------------------------------
  // thermal cause held until cool or until supply loss clears it, so retry alone cannot restart a hot die
  logic thermal_latched;
  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
      thermal_latched <= 1'b0;
    else if (!supply_ok)
      thermal_latched <= 1'b0; // R15
    else if (tsd)
      thermal_latched <= 1'b1;
    else if (cool)
      thermal_latched <= 1'b0; // R13
  end

  logic recovered;
  // retry expiry plus each cause cleared
  assign recovered = retry_done && !ocp && !tsd && !thermal_latched; // R8 R13 R14

  // ----------------------------------------
  // mode sequencer
  // ----------------------------------------
  mode_pkg::mode_type next_mode;
  always_comb
  begin
    next_mode = mode;
    case (mode)
      mode_pkg::ST_LOCKOUT:
        if (supply_ok)
          next_mode = mode_pkg::ST_SLEEP;
      mode_pkg::ST_SLEEP:
        if (wake_done && any_in)
          next_mode = mode_pkg::ST_ACTIVE; // R2 R6
      mode_pkg::ST_ACTIVE:
        if (ocp || tsd)
          next_mode = mode_pkg::ST_FAULT; // R7
        else if (sleep_done)
          next_mode = mode_pkg::ST_SLEEP; // R4
      mode_pkg::ST_FAULT:
        if (recovered)
          next_mode = mode_pkg::ST_ACTIVE; // R8 R14
      default:
        next_mode = mode_pkg::ST_LOCKOUT;
    endcase
    if (!supply_ok)
      next_mode = mode_pkg::ST_LOCKOUT; // R9 R10 R12 R15
  end

  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
      mode <= mode_pkg::ST_LOCKOUT;
    else
      mode <= next_mode;
  end

  // ----------------------------------------
  // output decode
  // ----------------------------------------
  mode_pkg::drive_type next_drive;
  always_comb
  begin
    next_drive = mode_pkg::DRIVE_RESET;
    case (next_mode)
      mode_pkg::ST_ACTIVE:
      begin
        next_drive.bridge_en = 1'b1; // R1 R3
        next_drive.circuits_en = 1'b1;
        next_drive.sense_en = split ? vm_ok : 1'b1; // R11 R12
        next_drive.fault_flag_n_oe = 1'b1;
      end
      mode_pkg::ST_FAULT:
      begin
        next_drive.circuits_en = 1'b1; // R13
        next_drive.sense_en = split ? vm_ok : 1'b1;
        next_drive.fault_flag_n_oe = 1'b0; // R7
      end
      mode_pkg::ST_LOCKOUT:
        next_drive.fault_flag_n_oe = 1'b0; // R15
      default:
        next_drive.fault_flag_n_oe = 1'b1; // R5
    endcase
  end

  // registered outputs; oe low means the flag pin is pulled low
  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      O_BRIDGE_EN <= 1'b0;
      O_BRIDGE_HIZ <= 1'b1;
      O_CIRCUITS_EN <= 1'b0;
      O_CURRENT_SENSE_OUT_EN <= 1'b0;
      O_FAULT_FLAG_N_OUT <= 1'b0;
      O_FAULT_FLAG_N_OE <= 1'b0;
    end
    else
    begin
      O_BRIDGE_EN <= next_drive.bridge_en;
      O_BRIDGE_HIZ <= !next_drive.bridge_en; // R5
      O_CIRCUITS_EN <= next_drive.circuits_en;
      O_CURRENT_SENSE_OUT_EN <= next_drive.sense_en;
      O_FAULT_FLAG_N_OUT <= 1'b0;
      O_FAULT_FLAG_N_OE <= next_drive.fault_flag_n_oe;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_fault_pulls_flag: assert property (@(posedge I_CLK) disable iff (I_RST) // R7
    (mode == mode_pkg::ST_ACTIVE && (ocp || tsd) && supply_ok) |=> (!O_FAULT_FLAG_N_OE && !O_BRIDGE_EN))
    else $error("fault did not pull flag or stop bridge");
  a_sleep_hiz: assert property (@(posedge I_CLK) disable iff (I_RST) // R5
    (next_mode == mode_pkg::ST_SLEEP) |=> (O_BRIDGE_HIZ && !O_CIRCUITS_EN))
    else $error("sleep left bridge driven");
  a_uvlo_lockout: assert property (@(posedge I_CLK) disable iff (I_RST) // R15
    !supply_ok |=> (mode == mode_pkg::ST_LOCKOUT && !O_FAULT_FLAG_N_OE && !O_BRIDGE_EN))
    else $error("undervoltage did not lock out");
  a_active_bridge: assert property (@(posedge I_CLK) disable iff (I_RST) // R1
    (mode == mode_pkg::ST_ACTIVE) |=> O_BRIDGE_EN || $past(next_mode) != mode_pkg::ST_ACTIVE)
    else $error("active without bridge");
  a_wake_needs_input: assert property (@(posedge I_CLK) disable iff (I_RST) // R2
    (mode == mode_pkg::ST_SLEEP && !any_in) |=> mode != mode_pkg::ST_ACTIVE)
    else $error("woke without input");
  a_thermal_hold: assert property (@(posedge I_CLK) disable iff (I_RST) // R13
    (mode == mode_pkg::ST_FAULT && thermal_latched) |=> mode != mode_pkg::ST_ACTIVE)
    else $error("left thermal fault while hot");
  a_fault_circuits: assert property (@(posedge I_CLK) disable iff (I_RST) // R13
    (mode == mode_pkg::ST_FAULT) |=> (O_CIRCUITS_EN || mode != mode_pkg::ST_FAULT || !supply_ok))
    else $error("internal circuits off in fault");
  a_sense_gate: assert property (@(posedge I_CLK) disable iff (I_RST) // R11
    (mode == mode_pkg::ST_ACTIVE && split && !vm_ok && supply_ok) |=> !O_CURRENT_SENSE_OUT_EN)
    else $error("sense given at low motor supply");
  // a fault cycle: active, then fault; the bridge must stay off for 8 cycles from fault entry
  sequence s_fault_entry;
    (mode == mode_pkg::ST_ACTIVE) ##1 (mode == mode_pkg::ST_FAULT);
  endsequence
  a_retry_wait: assert property (@(posedge I_CLK) disable iff (I_RST) // R14
    s_fault_entry |-> (!O_BRIDGE_EN) [*8])
    else $error("bridge back on before retry period");
  a_lockout_exit: assert property (@(posedge I_CLK) disable iff (I_RST) // R2
    (mode == mode_pkg::ST_LOCKOUT) |=> mode != mode_pkg::ST_ACTIVE)
    else $error("left lockout straight into active");
endmodule
`default_nettype wire

// [testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ----------------------------------------
  // stimulus, wires and partner
  // ----------------------------------------
  localparam int W = mode_pkg::WAKE_CYCLES;
  localparam int S = mode_pkg::SLEEP_CYCLES;
  localparam int R = mode_pkg::RETRY_CYCLES;
  typedef struct packed {logic [7:0] v; logic [4:0] exp; logic [4:0] care; int early; int hold;} row_type;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic want_a = 1'b0, want_b = 1'b0, split = 1'b0, logic_ok = 1'b1, motor_ok = 1'b1;
  logic overcurrent = 1'b0, over_trip = 1'b0, cooled = 1'b1;
  logic ctrl_a, ctrl_b, bridge_en, bridge_hiz, circuits_en, sense_en, flag_out, flag_oe;
  logic [4:0] outs;
  logic [4:0] prev = 5'h08;
  int fails = 0;
  int compares = 0;
  // open-drain flag with a pull-up: released reads high
  wire logic fault_flag_n = flag_oe ? 1'b1 : flag_out;
  assign outs = {bridge_en, bridge_hiz, circuits_en, sense_en, fault_flag_n};
  always #2.5 clk = ~clk;
  // rows: {a,b,split,logic_ok,motor_ok,oc,trip,cooled}, outputs {bridge,hiz,circ,sense,flag}
  row_type rows [14] = '{
    '{8'h99, 5'h17, 5'h1F, W, 10},
    '{8'h59, 5'h17, 5'h1F, 0, 300},
    '{8'h19, 5'h09, 5'h1D, S, 10},
    '{8'hD9, 5'h17, 5'h1F, W, 10},
    '{8'hDD, 5'h0C, 5'h1D, 0, 0},
    '{8'hD9, 5'h17, 5'h1F, R - 8, 10},
    '{8'hDA, 5'h0C, 5'h1D, 0, 0},
    '{8'hD8, 5'h0C, 5'h1D, 0, 400},
    '{8'hD9, 5'h17, 5'h1F, 0, 10},
    '{8'hD1, 5'h08, 5'h1F, 0, 10},
    '{8'hD9, 5'h17, 5'h1F, W, 10},
    '{8'hE9, 5'h08, 5'h1F, 0, 10},
    '{8'hF1, 5'h15, 5'h1F, W, 10},
    '{8'hF9, 5'h17, 5'h1F, 0, 10}};
  mcu_model partner_u (.clk(clk), .want_a(want_a), .want_b(want_b), .fault_flag_n(fault_flag_n),
    .bridge_ctrl_a(ctrl_a), .bridge_ctrl_b(ctrl_b), .fault_seen());
  motor_driver_mode_fault_control dut_u (.I_CLK(clk), .I_RST(rst), .I_BRIDGE_CTRL_A(ctrl_a),
    .I_BRIDGE_CTRL_B(ctrl_b), .I_SPLIT_SUPPLY(split), .I_LOGIC_SUPPLY_OK(logic_ok),
    .I_MOTOR_SUPPLY_OK(motor_ok), .I_OVERCURRENT(overcurrent), .I_OVER_THERMAL_TRIP(over_trip),
    .I_BELOW_THERMAL_HYSTERESIS(cooled), .O_BRIDGE_EN(bridge_en), .O_BRIDGE_HIZ(bridge_hiz),
    .O_CIRCUITS_EN(circuits_en), .O_CURRENT_SENSE_OUT_EN(sense_en), .O_FAULT_FLAG_N_OUT(flag_out),
    .O_FAULT_FLAG_N_OE(flag_oe));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input logic [4:0] seen, input logic [4:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // bridge held at its old level through early, then target reached and kept for hold
  task automatic run_row(input logic [7:0] v, input logic [4:0] exp, input logic [4:0] care,
    input int early, input int hold);
    int n;
    @(posedge clk);
    {want_a, want_b, split, logic_ok, motor_ok, overcurrent, over_trip, cooled} <= v;
    for (n = 0; n < early; n++)
    begin
      @(negedge clk);
      check({outs[4], 4'h0}, {prev[4], 4'h0});
    end
    n = 0;
    while ((outs & care) !== (exp & care) && n < 600)
    begin
      @(negedge clk);
      n++;
    end
    if (n == 600)
    begin
      fails++;
      summarize();
    end
    repeat (hold + 1)
    begin
      @(negedge clk);
      check(outs & care, exp & care);
    end
    prev = exp;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (11) @(posedge clk);
    @(negedge clk);
    check(outs, 5'h08);
    @(posedge clk);
    rst <= 1'b0;
    run_row(8'h19, 5'h09, 5'h1D, 0, 5);
    foreach (rows[i])
      run_row(rows[i].v, rows[i].exp, rows[i].care, rows[i].early, rows[i].hold);
    // both low for less than the sleep delay must not stop the bridge
    run_row(8'h39, 5'h17, 5'h1F, 0, 100);
    run_row(8'hF9, 5'h17, 5'h1F, 0, 300);
    // a short wake pulse is ignored while asleep
    run_row(8'h39, 5'h09, 5'h1D, S, 10);
    run_row(8'hB9, 5'h09, 5'h1D, 0, 100);
    run_row(8'h39, 5'h09, 5'h1D, 0, 300);
    // reset in mid-run clears everything, then a full wake
    @(posedge clk);
    rst <= 1'b1;
    @(negedge clk);
    check(outs, 5'h08);
    @(posedge clk);
    rst <= 1'b0;
    prev = 5'h08;
    run_row(8'hB9, 5'h17, 5'h1F, W, 10);
    summarize();
  end
endmodule
`default_nettype wire
